// File: rtl/config_optional_pin_control.sv
// optional configuration pin control with apb registers
`timescale 1ns/1ps
`default_nettype none
module config_optional_pin_control (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cfg_pins_pkg::ADDR_W-1:0] paddr,
   input wire logic [cfg_pins_pkg::DATA_W-1:0] pwdata,
   output logic [cfg_pins_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic config_request_n,
   input wire logic cfg_frame_valid,
   input wire logic [cfg_pins_pkg::NUM_PINS-1:0] cfg_frame_options,
   input wire logic cfg_data_done,
   input wire logic [cfg_pins_pkg::NUM_PINS-1:0] pin_in,
   output logic [cfg_pins_pkg::NUM_PINS-1:0] pin_out,
   output logic [cfg_pins_pkg::NUM_PINS-1:0] pin_oe,
   output logic user_mode,
   output logic global_io_tristate,
   output logic global_register_clear,
   output logic irq
);
   import cfg_pins_pkg::*;

   typedef struct packed {
      cfg_state_type state;
      logic [NUM_PINS-1:0] options;
      logic options_loaded;
      logic [NUM_PINS-1:0] user_out;
      logic [NUM_PINS-1:0] user_oe;
      logic [LEN_W-1:0] init_len;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic [DATA_W-1:0] prdata;
      logic timer_start;
   } ctrl_state_type;

   ctrl_state_type s;
   ctrl_state_type next_s;

   logic timer_done;
   logic init_done_drive_low;
   logic setup_phase;
   logic access_phase;
   logic wr_en;
   logic addr_ok;
   logic [IRQ_W-1:0] events;
   logic [IRQ_W-1:0] w1c;
   logic [DATA_W-1:0] rd_value;
   logic [NUM_PINS-1:0] pin_oe_mux;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode

   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign pready = 1'b1;
   assign wr_en = access_phase & pwrite & addr_ok;

   always_comb begin
      addr_ok = 1'b1;
      case (paddr)
         OFS_CTRL: addr_ok = 1'b1;
         OFS_STATUS: addr_ok = 1'b1;
         OFS_IRQ_STATUS: addr_ok = 1'b1;
         OFS_IRQ_MASK: addr_ok = 1'b1;
         OFS_INIT_LEN: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   assign pslverr = access_phase & ~addr_ok;

   always_comb begin
      rd_value = '0;
      case (paddr)
         OFS_CTRL: begin
            rd_value[CTRL_OUT_LSB +: NUM_PINS] = s.user_out;
            rd_value[CTRL_OE_LSB +: NUM_PINS] = s.user_oe;
         end
         OFS_STATUS: begin
            rd_value[STAT_STATE_LSB +: 4] = s.state;
            rd_value[STAT_OPT_LSB +: NUM_PINS] = s.options;
            rd_value[STAT_PIN_LSB +: NUM_PINS] = pin_in;
            rd_value[STAT_DRIVE_BIT] = init_done_drive_low;
            rd_value[STAT_LOADED_BIT] = s.options_loaded;
         end
         OFS_IRQ_STATUS: rd_value[IRQ_W-1:0] = s.irq_status;
         OFS_IRQ_MASK: rd_value[IRQ_W-1:0] = s.irq_mask;
         OFS_INIT_LEN: rd_value[LEN_W-1:0] = s.init_len;
         default: rd_value = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration sequence and registers

   always_comb begin
      next_s = s;
      next_s.timer_start = 1'b0;
      events = '0;
      w1c = '0;

      if (setup_phase && !pwrite) begin
         next_s.prdata = rd_value;
      end

      if (wr_en) begin
         case (paddr)
            OFS_CTRL: begin
               next_s.user_out = pwdata[CTRL_OUT_LSB +: NUM_PINS];
               next_s.user_oe = pwdata[CTRL_OE_LSB +: NUM_PINS];
            end
            OFS_IRQ_STATUS: w1c = pwdata[IRQ_W-1:0];
            OFS_IRQ_MASK: next_s.irq_mask = pwdata[IRQ_W-1:0];
            OFS_INIT_LEN: next_s.init_len = pwdata[LEN_W-1:0];
            default: next_s.user_out = s.user_out;
         endcase
      end

      case (s.state)
         ST_IDLE: begin
            // request low: options forgotten, status pin floats
            next_s.options = '0;
            next_s.options_loaded = 1'b0;
            if (config_request_n) begin
               next_s.state = ST_CONFIG;
               events[IRQ_CFG_START] = 1'b1;
            end
         end
         ST_CONFIG: begin
            if (!config_request_n) begin
               next_s.state = ST_IDLE;
               events[IRQ_ABORT] = 1'b1;
            end else if (cfg_frame_valid && !s.options_loaded) begin
               // first frame carries the option bits
               next_s.options = cfg_frame_options;
               next_s.options_loaded = 1'b1;
               events[IRQ_OPT_LOADED] = 1'b1;
            end else if (cfg_data_done && s.options_loaded) begin
               next_s.state = ST_INIT;
               next_s.timer_start = 1'b1;
            end
         end
         ST_INIT: begin
            if (!config_request_n) begin
               next_s.state = ST_IDLE;
               events[IRQ_ABORT] = 1'b1;
            end else if (timer_done) begin
               // release status pin and enter user mode together
               next_s.state = ST_USER;
               events[IRQ_USER_MODE] = 1'b1;
            end
         end
         ST_USER: begin
            if (!config_request_n) begin
               next_s.state = ST_IDLE;
               events[IRQ_ABORT] = 1'b1;
            end
         end
         default: begin
            next_s.state = ST_IDLE;
         end
      endcase

      // a new event wins over a clear in the same cycle
      next_s.irq_status = (s.irq_status & ~w1c) | events;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s.state <= ST_IDLE;
         s.options <= '0;
         s.options_loaded <= 1'b0;
         s.user_out <= CTRL_OUT_RESET;
         s.user_oe <= CTRL_OE_RESET;
         s.init_len <= INIT_LEN_RESET;
         s.irq_status <= '0;
         s.irq_mask <= IRQ_MASK_RESET;
         s.prdata <= '0;
         s.timer_start <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // status pin held low from option load until initialization ends
   assign init_done_drive_low = s.options[PIN_INIT_DONE] & s.options_loaded
                                & (s.state == ST_CONFIG || s.state == ST_INIT);

   assign user_mode = (s.state == ST_USER);
   assign global_io_tristate = s.options[PIN_OE] & ~pin_in[PIN_OE];
   assign global_register_clear = s.options[PIN_CLR] & ~pin_in[PIN_CLR];
   assign irq = |(s.irq_status & s.irq_mask);
   assign prdata = s.prdata;
   assign pin_oe = pin_oe_mux;

   init_timer u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .start(s.timer_start),
      .abort(~config_request_n),
      .use_user_clock(s.options[PIN_USER_CLK]),
      .user_clock_level(pin_in[PIN_USER_CLK]),
      .length(s.init_len),
      .done(timer_done)
   );

   pin_function_mux u_mux (
      .option(s.options),
      .user_mode(user_mode),
      .io_tristate(global_io_tristate),
      .user_out(s.user_out),
      .user_oe(s.user_oe),
      .init_done_drive_low(init_done_drive_low),
      .pin_out(pin_out),
      .pin_oe(pin_oe_mux)
   );

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_float_request_low;
      !config_request_n |=> !pin_oe[PIN_INIT_DONE] || !s.options[PIN_INIT_DONE];
   endproperty
   a_float_request_low: assert property (p_float_request_low)
      else $error("status pin driven while configuration request low");

   property p_float_before_load;
      s.state == ST_CONFIG && !s.options_loaded |-> !pin_oe[PIN_INIT_DONE];
   endproperty
   a_float_before_load: assert property (p_float_before_load)
      else $error("status pin driven before options loaded");

   property p_low_after_load;
      s.state == ST_CONFIG && config_request_n && !s.options_loaded
         && cfg_frame_valid && cfg_frame_options[PIN_INIT_DONE]
         |=> pin_oe[PIN_INIT_DONE] && !pin_out[PIN_INIT_DONE];
   endproperty
   a_low_after_load: assert property (p_low_after_load)
      else $error("status pin not pulled low after option load");

   property p_release_with_user;
      s.state == ST_INIT && config_request_n && timer_done
         |=> user_mode && s.irq_status[IRQ_USER_MODE]
         && (!pin_oe[PIN_INIT_DONE] || !s.options[PIN_INIT_DONE]);
   endproperty
   a_release_with_user: assert property (p_release_with_user)
      else $error("status release and user mode not together");

   property p_user_clock_gates_done;
      s.options[PIN_USER_CLK] && s.state == ST_INIT && !timer_done
         |=> s.state != ST_USER;
   endproperty
   a_user_clock_gates_done: assert property (p_user_clock_gates_done)
      else $error("user mode entered without timer completion");

   property p_tristate_override;
      s.options[PIN_OE] && !pin_in[PIN_OE] |-> global_io_tristate
         && ((pin_oe & ~s.options) == '0);
   endproperty
   a_tristate_override: assert property (p_tristate_override)
      else $error("override low but I/O still driven");

   property p_clear_follows_pin;
      s.options[PIN_CLR] |-> global_register_clear == !pin_in[PIN_CLR];
   endproperty
   a_clear_follows_pin: assert property (p_clear_follows_pin)
      else $error("device-wide clear does not follow its pin");

   property p_user_io_when_off;
      user_mode && !global_io_tristate
         |-> (pin_oe & ~s.options) == (s.user_oe & ~s.options)
         && (pin_out & ~s.options) == (s.user_out & ~s.options);
   endproperty
   a_user_io_when_off: assert property (p_user_io_when_off)
      else $error("pin with option off not acting as user I/O");

   property p_never_drive_high;
      s.options[PIN_INIT_DONE] |-> !pin_out[PIN_INIT_DONE];
   endproperty
   a_never_drive_high: assert property (p_never_drive_high)
      else $error("status pin driven high");

   property p_release_on_request;
      !config_request_n
         |=> pin_oe == '0 && !user_mode;
   endproperty
   a_release_on_request: assert property (p_release_on_request)
      else $error("pins still driven after configuration request low");

   property p_options_clear_idle;
      s.state == ST_IDLE |=> s.options == '0 && !s.options_loaded;
   endproperty
   a_options_clear_idle: assert property (p_options_clear_idle)
      else $error("option bits kept while idle");

   property p_low_through_init;
      s.state == ST_INIT && s.options[PIN_INIT_DONE]
         |-> pin_oe[PIN_INIT_DONE] && !pin_out[PIN_INIT_DONE];
   endproperty
   a_low_through_init: assert property (p_low_through_init)
      else $error("status pin not held low during initialization");

   property p_frame_once;
      s.state == ST_CONFIG && s.options_loaded && config_request_n
         |=> s.options == $past(s.options);
   endproperty
   a_frame_once: assert property (p_frame_once)
      else $error("option bits reloaded by a later frame");

   property p_user_io_off_outside_user;
      !user_mode |-> (pin_oe & ~s.options) == '0;
   endproperty
   a_user_io_off_outside_user: assert property (p_user_io_off_outside_user)
      else $error("user I/O driven outside user mode");

   property p_inputs_never_driven;
      !(s.options[PIN_USER_CLK] && pin_oe[PIN_USER_CLK])
         && !(s.options[PIN_OE] && pin_oe[PIN_OE])
         && !(s.options[PIN_CLR] && pin_oe[PIN_CLR]);
   endproperty
   a_inputs_never_driven: assert property (p_inputs_never_driven)
      else $error("dedicated input pin driven");

   property p_overrides_off;
      (!s.options[PIN_OE] |-> !global_io_tristate)
         and (!s.options[PIN_CLR] |-> !global_register_clear);
   endproperty
   a_overrides_off: assert property (p_overrides_off)
      else $error("override active with its option off");

   c_user_mode: cover property (s.state == ST_INIT ##1 s.state == ST_USER);
   c_abort: cover property (s.state == ST_INIT ##1 s.state == ST_IDLE);
   c_irq: cover property ($rose(irq));
   c_user_clock_init: cover property (s.options[PIN_USER_CLK] && timer_done);
   c_override_tristate: cover property (global_io_tristate && user_mode);

endmodule
`default_nettype wire

// File: shared/cfg_pins_pkg.sv
// constants and types for the optional configuration pin block
package cfg_pins_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NUM_PINS = 4;
   localparam int LEN_W = 16;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFS_INIT_LEN = 8'h10;

   // pin indices, also option bit positions
   localparam int PIN_USER_CLK = 0;
   localparam int PIN_INIT_DONE = 1;
   localparam int PIN_OE = 2;
   localparam int PIN_CLR = 3;

   // field positions
   localparam int CTRL_OUT_LSB = 0;
   localparam int CTRL_OE_LSB = 4;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_OPT_LSB = 4;
   localparam int STAT_PIN_LSB = 8;
   localparam int STAT_DRIVE_BIT = 12;
   localparam int STAT_LOADED_BIT = 13;

   // interrupt event bits
   localparam int IRQ_W = 4;
   localparam int IRQ_CFG_START = 0;
   localparam int IRQ_OPT_LOADED = 1;
   localparam int IRQ_USER_MODE = 2;
   localparam int IRQ_ABORT = 3;

   // reset values
   localparam logic [LEN_W-1:0] INIT_LEN_RESET = 16'h0010;
   localparam logic [3:0] CTRL_OUT_RESET = 4'h0;
   localparam logic [3:0] CTRL_OE_RESET = 4'h0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_CONFIG = 4'h2,
      ST_INIT = 4'h4,
      ST_USER = 4'h8
   } cfg_state_type;

endpackage

// File: rtl/init_timer.sv
// initialization length counter, paced by system clock cycles or user start-up clock rising edges
`timescale 1ns/1ps
`default_nettype none
module init_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic abort,
   input wire logic use_user_clock,
   input wire logic user_clock_level,
   input wire logic [cfg_pins_pkg::LEN_W-1:0] length,
   output logic done
);
   import cfg_pins_pkg::*;

   typedef struct packed {
      logic prev_clock;
      logic busy;
      logic done;
      logic [LEN_W-1:0] count;
   } timer_state_type;

   timer_state_type s;
   timer_state_type next_s;
   logic tick;

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      next_s.prev_clock = user_clock_level;
      // rising edges of the start-up clock pace the sequence
      tick = use_user_clock ? (user_clock_level & ~s.prev_clock) : 1'b1;
      if (abort) begin
         next_s.busy = 1'b0;
      end else if (start) begin
         next_s.busy = 1'b1;
         next_s.count = '0;
      end else if (s.busy && tick) begin
         if (s.count + 16'h0001 >= length) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end else begin
            next_s.count = s.count + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '{prev_clock: 1'b1, busy: 1'b0, done: 1'b0, count: '0};
      end else begin
         s <= next_s;
      end
   end

   assign done = s.done;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_hold_without_edge;
      s.busy && use_user_clock && !(user_clock_level && !s.prev_clock) && !start && !abort
         |=> !done && s.count == $past(s.count);
   endproperty
   a_hold_without_edge: assert property (p_hold_without_edge)
      else $error("init count moved without a start-up clock edge");

endmodule
`default_nettype wire

// File: rtl/pin_function_mux.sv
// per pin choice between dedicated function and user I/O
`timescale 1ns/1ps
`default_nettype none
module pin_function_mux (
   input wire logic [cfg_pins_pkg::NUM_PINS-1:0] option,
   input wire logic user_mode,
   input wire logic io_tristate,
   input wire logic [cfg_pins_pkg::NUM_PINS-1:0] user_out,
   input wire logic [cfg_pins_pkg::NUM_PINS-1:0] user_oe,
   input wire logic init_done_drive_low,
   output logic [cfg_pins_pkg::NUM_PINS-1:0] pin_out,
   output logic [cfg_pins_pkg::NUM_PINS-1:0] pin_oe
);
   import cfg_pins_pkg::*;

   genvar i;
   generate
      for (i = 0; i < NUM_PINS; i++) begin : g_pin
         if (i == PIN_INIT_DONE) begin : g_status
            // open drain when its option is set: only low or released; user I/O otherwise
            assign pin_out[i] = option[i] ? 1'b0 : user_out[i];
            assign pin_oe[i] = option[i] ? init_done_drive_low
                               : (user_mode & user_oe[i] & ~io_tristate);
         end else begin : g_input
            // dedicated inputs never drive
            assign pin_out[i] = option[i] ? 1'b0 : user_out[i];
            assign pin_oe[i] = option[i] ? 1'b0
                               : (user_mode & user_oe[i] & ~io_tristate);
         end
      end
   endgenerate

endmodule
`default_nettype wire

// File: testbench/host_board_model.sv
// board side model: pull-ups, user start-up clock, override levels
`timescale 1ns/1ps
`default_nettype none
module host_board_model (
   input wire logic clk,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic clk_run,
   input wire logic oe_level,
   input wire logic clr_level,
   output logic [3:0] pin_in,
   output logic [7:0] rises
);
   logic uclk = 1'b0;
   logic [1:0] div = 2'h0;
   logic prev = 1'b1;
   initial rises = 8'h00;
   ////////////////////////////////////////////////////////////////
   // start-up clock runs only when asked, else weak pull-up
   always @(posedge clk) begin
      if (clk_run) begin
         div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
         if (div == 2'h2) uclk <= ~uclk;
      end
   end
   assign pin_in[0] = pin_oe[0] ? pin_out[0] : (clk_run ? uclk : 1'b1);
   // open-drain status line, external pull-up
   assign pin_in[1] = pin_oe[1] ? pin_out[1] : 1'b1;
   assign pin_in[2] = pin_oe[2] ? pin_out[2] : oe_level;
   assign pin_in[3] = pin_oe[3] ? pin_out[3] : clr_level;
   ////////////////////////////////////////////////////////////////
   // monitor counts low-to-high steps of status line
   always @(posedge clk) begin
      prev <= pin_in[1];
      if (!prev && pin_in[1]) rises <= rises + 8'h01;
   end
   // test port inputs not modelled, held steady
endmodule
`default_nettype wire

// File: testbench/tb_config_optional_pin_control.sv
// self-checking bench for the optional configuration pin block
`timescale 1ns/1ps
`default_nettype none
module tb_config_optional_pin_control;
   import cfg_pins_pkg::*;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_type;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, user_mode, tri_o, clr_o, irq;
   logic req_n = 1'b0, frame_v = 1'b0, data_done = 1'b0;
   logic [3:0] frame_o = 4'h0;
   logic [3:0] pin_in, pin_out, pin_oe;
   logic run = 1'b0, oe_lvl = 1'b1, clr_lvl = 1'b1;
   logic [7:0] rises;
   logic [15:0] len;
   logic [3:0] uo;
   int n_fail = 0, n_compared = 0, seed = 32'h5fa0;
   note_type q[$];
   note_type nt;
   always #5 clk = ~clk;
   config_optional_pin_control DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .config_request_n(req_n), .cfg_frame_valid(frame_v),
      .cfg_frame_options(frame_o), .cfg_data_done(data_done), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .user_mode(user_mode),
      .global_io_tristate(tri_o), .global_register_clear(clr_o), .irq(irq));
   host_board_model board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .clk_run(run), .oe_level(oe_lvl), .clr_level(clr_lvl), .pin_in(pin_in),
      .rises(rises));
   ////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // apb transfer; expected read data, mask and error noted
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      input logic [31:0] ex, input logic [31:0] m, input logic e);
      int k;
      q.push_back('{ex, m, e});
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         n_fail++;
         finish_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // response watcher
   always @(posedge clk) begin
      if (psel && penable && pready) begin
         nt = q.pop_front();
         chk("prdata", nt.d, prdata & nt.m);
         chk("pslverr", {31'h0, nt.e}, {31'h0, pslverr});
      end
   end
   task automatic wait_um();
      int k;
      k = 0;
      while (user_mode !== 1'b1 && k < 2000) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (user_mode !== 1'b1) begin
         n_fail++;
         finish_test();
      end
   endtask
   task automatic configure(input logic [3:0] o);
      @(posedge clk);
      req_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("float", 32'h1, {30'h0, pin_oe[1], pin_in[1]});
      @(posedge clk);
      frame_v <= 1'b1;
      frame_o <= o;
      @(posedge clk);
      frame_v <= 1'b0;
      #1 chk("drive_low", {30'h0, o[1], 1'b0}, {30'h0, pin_oe[1], pin_out[1] & pin_oe[1]});
      @(posedge clk);
      data_done <= 1'b1;
      @(posedge clk);
      data_done <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0, 32'h0, 32'hffff_ffff, 1'b0);
      apb(1'b0, OFS_STATUS, 32'h0, 32'h0f01, 32'h3fff, 1'b0);
      apb(1'b0, OFS_IRQ_MASK, 32'h0, 32'h0, 32'hffff_ffff, 1'b0);
      apb(1'b0, OFS_INIT_LEN, 32'h0, 32'h10, 32'hffff_ffff, 1'b0);
      apb(1'b1, 8'h14, 32'hffff_ffff, 32'h0, 32'h0, 1'b1);
      apb(1'b0, 8'h14, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
      // status pin across a full configuration
      len = 16'h3 + (16'($random(seed)) & 16'h7);
      apb(1'b1, OFS_INIT_LEN, {16'h0, len}, 32'h0, 32'h0, 1'b0);
      apb(1'b1, OFS_IRQ_MASK, 32'hf, 32'h0, 32'h0, 1'b0);
      configure(4'b0010);
      repeat (len + 16'h1) @(posedge clk);
      #1 chk("init_hold", 32'h1, {30'h0, user_mode, pin_oe[1]});
      @(posedge clk);
      #1 chk("release", 32'h2, {30'h0, user_mode, pin_oe[1]});
      wait_um();
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b0, OFS_STATUS, 32'h0, 32'h2f28, 32'h3fff, 1'b0);
      chk("monitor", 32'h1, {24'h0, rises});
      apb(1'b0, OFS_IRQ_STATUS, 32'h0, 32'h7, 32'hf, 1'b0);
      apb(1'b1, OFS_IRQ_STATUS, 32'h7, 32'h0, 32'h0, 1'b0);
      #1 chk("irq_clear", 32'h0, {31'h0, irq});
      // user I/O and device-wide overrides
      @(posedge clk);
      req_n <= 1'b0;
      uo = 4'($random(seed));
      apb(1'b1, OFS_CTRL, {24'h0, 4'hf, uo}, 32'h0, 32'h0, 1'b0);
      configure(4'b1100);
      wait_um();
      chk("user_io", {26'h0, 4'h3, uo[1:0]}, {26'h0, pin_oe, pin_out[1:0]});
      @(posedge clk);
      oe_lvl <= 1'b0;
      clr_lvl <= 1'b0;
      @(posedge clk);
      #1 chk("override_low", 32'h30, {26'h0, tri_o, clr_o, pin_oe});
      @(posedge clk);
      oe_lvl <= 1'b1;
      clr_lvl <= 1'b1;
      @(posedge clk);
      #1 chk("override_high", 32'h03, {26'h0, tri_o, clr_o, pin_oe});
      // start-up clock paces initialization
      @(posedge clk);
      req_n <= 1'b0;
      apb(1'b1, OFS_INIT_LEN, 32'h4, 32'h0, 32'h0, 1'b0);
      configure(4'b0001);
      repeat (30) @(posedge clk);
      #1 chk("no_uclk", 32'h0, {31'h0, user_mode});
      @(posedge clk);
      run <= 1'b1;
      wait_um();
      @(posedge clk);
      run <= 1'b0;
      req_n <= 1'b0;
      apb(1'b1, OFS_IRQ_STATUS, 32'hf, 32'h0, 32'h0, 1'b0);
      // abort in the middle of initialization
      configure(4'b0010);
      @(posedge clk);
      req_n <= 1'b0;
      @(posedge clk);
      #1 chk("abort", 32'h0, {27'h0, user_mode, pin_oe});
      apb(1'b0, OFS_IRQ_STATUS, 32'h0, 32'hb, 32'hf, 1'b0);
      finish_test();
   end
endmodule
`default_nettype wire
